// file: dpsf_pkg.sv
`default_nettype none

package dpsf_pkg;

    // Bus clock and the pin timing the controller honours, in ns.
    localparam int CLK_PERIOD_NS = 25;
    localparam int WR_PULSE_NS   = 20;
    localparam int RD_ACCESS_NS  = 20;
    localparam int GAP_NS        = 15;
    localparam int SYNC_STAGES   = 2;

    // Least times round up to whole cycles.
    localparam int WR_CYC_I  = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_CYC_I  = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC_I = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Timer loads; the read window also covers the input synchroniser.
    localparam logic [3:0] WR_LOAD  = 4'(WR_CYC_I - 1);
    localparam logic [3:0] RD_LOAD  = 4'(RD_CYC_I + SYNC_STAGES - 1);
    localparam logic [3:0] GAP_LOAD = 4'(GAP_CYC_I - 1);
    localparam logic [3:0] TIMER_RESET = 4'h0;

    // Flag addressing.
    localparam int         FLAG_COUNT = 8;
    localparam logic [2:0] IDX_RESET  = 3'h0;
    localparam logic [2:0] IDX_LAST   = 3'(FLAG_COUNT - 1);

    typedef enum logic [1:0] {
        DPSF_OP_READ    = 2'h0,
        DPSF_OP_ACQUIRE = 2'h1,
        DPSF_OP_RELEASE = 2'h2,
        DPSF_OP_INIT    = 2'h3
    } dpsf_op_t;

    typedef enum logic [4:0] {
        DPSF_ST_IDLE = 5'h01,
        DPSF_ST_WR   = 5'h02,
        DPSF_ST_GAP  = 5'h04,
        DPSF_ST_RD   = 5'h08,
        DPSF_ST_DONE = 5'h10
    } dpsf_state_t;

    typedef struct packed {
        dpsf_op_t   op;
        logic [2:0] index;
    } dpsf_cmd_t;

    typedef struct packed {
        logic flag;
        logic owned;
        logic mixed;
    } dpsf_resp_t;

    typedef struct packed {
        logic       flag_space_select_n;
        logic       array_enable_n;
        logic       rw_n;
        logic       output_enable_n;
        logic [2:0] flag_index_lines;
    } dpsf_pins_t;

    localparam dpsf_pins_t PINS_IDLE  = '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0};
    localparam dpsf_resp_t RESP_RESET = '{1'b1, 1'b0, 1'b0};

endpackage

`default_nettype wire

// file: dpsf_host.sv
`timescale 1ns/10ps
`default_nettype none

module dpsf_host #(
    parameter int DATA_W = 16
) (
    input  wire logic               clock_i,      // 40 MHz clock.
    input  wire logic               reset_n_i,    // Asynchronous reset, active low.
    input  wire logic               cmd_valid_i,  // Command offered.
    input  wire dpsf_pkg::dpsf_cmd_t cmd_i,       // Operation and flag index.
    output logic                    cmd_ready_o,  // Controller idle, command taken.
    output logic                    resp_valid_o, // One-cycle completion pulse.
    output dpsf_pkg::dpsf_resp_t    resp_o,       // Read-back result; reset value after a release or init.
    output dpsf_pkg::dpsf_pins_t    pins_o,       // Port control pins.
    output logic [DATA_W-1:0]       data_o,       // Data pins, driven value.
    output logic                    data_oe_n_o,  // Low while driving data pins.
    input  wire logic [DATA_W-1:0]  data_i        // Data pins, sampled value.
);
    import dpsf_pkg::*;

    dpsf_state_t       state_reg;
    dpsf_op_t          op_reg;
    logic [2:0]        idx_reg;
    logic [3:0]        timer_reg;
    logic              rd_done_reg;
    dpsf_pins_t        pins_reg;
    logic [DATA_W-1:0] data_reg;
    logic              data_oe_n_reg;
    logic [DATA_W-1:0] sync1_reg;
    logic [DATA_W-1:0] sync2_reg;
    dpsf_resp_t        resp_reg;
    logic              cmd_fire;
    logic              timer_done;
    logic              wr_value;

    // Handshake is combinational; commands are only taken while idle.
    assign cmd_ready_o  = (state_reg == DPSF_ST_IDLE);
    assign cmd_fire     = cmd_valid_i && cmd_ready_o;
    assign resp_valid_o = (state_reg == DPSF_ST_DONE);
    assign timer_done   = (timer_reg == TIMER_RESET);
    assign resp_o       = resp_reg;
    assign pins_o       = pins_reg;
    assign data_o       = data_reg;
    assign data_oe_n_o  = data_oe_n_reg;

    // Acquire writes zero; release and init write one.
    // request and release
    assign wr_value = (op_reg != DPSF_OP_ACQUIRE);

    // Sequencer: acquire runs write, gap, read-back, gap, done; read has no write, release and init no read-back. The gap after every
    // strobe drops the select so the device re-latches on the next read.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg   <= DPSF_ST_IDLE;
            op_reg      <= DPSF_OP_READ;
            idx_reg     <= IDX_RESET;
            timer_reg   <= TIMER_RESET;
            rd_done_reg <= 1'b0;
        end else begin
            case (state_reg)
                DPSF_ST_IDLE: begin
                    if (cmd_fire) begin
                        op_reg  <= cmd_i.op;
                        idx_reg <= (cmd_i.op == DPSF_OP_INIT) ? IDX_RESET : cmd_i.index;
                        if (cmd_i.op == DPSF_OP_READ) begin
                            state_reg   <= DPSF_ST_RD;
                            timer_reg   <= RD_LOAD;
                            rd_done_reg <= 1'b1;
                        end else begin
                            state_reg   <= DPSF_ST_WR;
                            timer_reg   <= WR_LOAD;
                            rd_done_reg <= 1'b0;
                        end
                    end
                end
                DPSF_ST_WR: begin
                    if (timer_done) begin
                        state_reg <= DPSF_ST_GAP;
                        timer_reg <= GAP_LOAD;
                    end else begin
                        timer_reg <= timer_reg - 4'h1;
                    end
                end
                DPSF_ST_GAP: begin
                    if (!timer_done) begin
                        timer_reg <= timer_reg - 4'h1;
                    end else if (op_reg == DPSF_OP_ACQUIRE && !rd_done_reg) begin
                        state_reg   <= DPSF_ST_RD;
                        timer_reg   <= RD_LOAD;
                        rd_done_reg <= 1'b1;
                    end else if (op_reg == DPSF_OP_INIT && idx_reg != IDX_LAST) begin
                        idx_reg   <= idx_reg + 3'h1;
                        state_reg <= DPSF_ST_WR;
                        timer_reg <= WR_LOAD;
                    end else begin
                        state_reg <= DPSF_ST_DONE;
                    end
                end
                DPSF_ST_RD: begin
                    if (timer_done) begin
                        state_reg <= DPSF_ST_GAP;
                        timer_reg <= GAP_LOAD;
                    end else begin
                        timer_reg <= timer_reg - 4'h1;
                    end
                end
                DPSF_ST_DONE: begin
                    state_reg <= DPSF_ST_IDLE;
                end
                default: begin
                    state_reg <= DPSF_ST_IDLE;
                end
            endcase
        end
    end

    // Pin drive follows the state entered on the same edge. Array enable
    // stays high throughout so flag cycles never touch the memory array.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pins_reg      <= PINS_IDLE;
            data_reg      <= '0;
            data_oe_n_reg <= 1'b1;
        end else begin
            pins_reg      <= PINS_IDLE;
            data_oe_n_reg <= 1'b1;
            pins_reg.flag_index_lines <= idx_reg;
            if ((state_reg == DPSF_ST_IDLE && cmd_fire && cmd_i.op != DPSF_OP_READ) ||
                (state_reg == DPSF_ST_WR && !timer_done) ||
                (state_reg == DPSF_ST_GAP && timer_done && op_reg == DPSF_OP_INIT &&
                 idx_reg != IDX_LAST)) begin
                pins_reg.flag_space_select_n <= 1'b0;
                pins_reg.rw_n                <= 1'b0;
                data_oe_n_reg                <= 1'b0;
            end
            if ((state_reg == DPSF_ST_IDLE && cmd_fire && cmd_i.op == DPSF_OP_READ) ||
                (state_reg == DPSF_ST_RD && !timer_done) ||
                (state_reg == DPSF_ST_GAP && timer_done && op_reg == DPSF_OP_ACQUIRE &&
                 !rd_done_reg)) begin
                pins_reg.flag_space_select_n <= 1'b0;
                pins_reg.output_enable_n     <= 1'b0;
            end
            if (state_reg == DPSF_ST_IDLE && cmd_fire) begin
                pins_reg.flag_index_lines <= (cmd_i.op == DPSF_OP_INIT) ? IDX_RESET
                                                                       : cmd_i.index;
            end else if (state_reg == DPSF_ST_GAP && timer_done &&
                         op_reg == DPSF_OP_INIT && idx_reg != IDX_LAST) begin
                pins_reg.flag_index_lines <= idx_reg + 3'h1;
            end
            if (state_reg == DPSF_ST_IDLE && cmd_fire) begin
                data_reg <= {DATA_W{cmd_i.op != DPSF_OP_ACQUIRE}};
            end else begin
                data_reg <= {DATA_W{wr_value}};
            end
        end
    end

    // Two-stage synchroniser on the data pins; only stage two is read.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= data_i;
            sync2_reg <= sync1_reg;
        end
    end

    // Result capture on the last read cycle. A failed acquire leaves the
    // request latched in the device; the user must poll or release it.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            resp_reg <= RESP_RESET;
        end else if (cmd_fire) begin
            resp_reg <= RESP_RESET;
        end else if (state_reg == DPSF_ST_RD && timer_done) begin
            resp_reg.flag  <= sync2_reg[0];
            resp_reg.mixed <= !((&sync2_reg) || (~|sync2_reg));
            resp_reg.owned <= (op_reg == DPSF_OP_ACQUIRE) && (~|sync2_reg);
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    wr_strobe_pins_a: assert property (
        state_reg == DPSF_ST_WR |-> !pins_o.flag_space_select_n && !pins_o.rw_n &&
            pins_o.array_enable_n && !data_oe_n_o)
        else $error("write cycle pins wrong");

    rd_strobe_pins_a: assert property (
        state_reg == DPSF_ST_RD |-> !pins_o.flag_space_select_n &&
            !pins_o.output_enable_n && pins_o.rw_n && data_oe_n_o)
        else $error("read cycle pins wrong");

    rd_deselect_a: assert property (
        state_reg == DPSF_ST_RD ##1 state_reg == DPSF_ST_GAP |->
            pins_o.flag_space_select_n && pins_o.output_enable_n)
        else $error("select not dropped after read");

    index_follows_a: assert property (
        cmd_fire && cmd_i.op != DPSF_OP_INIT |=> pins_o.flag_index_lines == $past(cmd_i.index))
        else $error("flag index not driven");

    acquire_zero_a: assert property (
        state_reg == DPSF_ST_WR |-> data_o[0] == (op_reg != DPSF_OP_ACQUIRE))
        else $error("written flag value wrong");

    acquire_readback_a: assert property (
        cmd_fire && cmd_i.op == DPSF_OP_ACQUIRE |-> ##[2:12] state_reg == DPSF_ST_RD)
        else $error("acquire not read back");

    owned_zero_a: assert property (
        resp_valid_o && resp_o.owned |-> !resp_o.flag && op_reg == DPSF_OP_ACQUIRE)
        else $error("ownership without zero read");

    init_all_a: assert property (
        resp_valid_o && op_reg == DPSF_OP_INIT |-> idx_reg == IDX_LAST)
        else $error("init ended early");

    no_stall_a: assert property (
        cmd_fire |-> ##[1:40] resp_valid_o)
        else $error("command never completed");

    idle_standby_a: assert property (
        state_reg == DPSF_ST_IDLE |-> pins_o.flag_space_select_n && pins_o.array_enable_n)
        else $error("idle port not in standby");

    acq_won_c:  cover property (resp_valid_o && op_reg == DPSF_OP_ACQUIRE && resp_o.owned);
    acq_lost_c: cover property (resp_valid_o && op_reg == DPSF_OP_ACQUIRE && !resp_o.owned);
    init_c:     cover property (resp_valid_o && op_reg == DPSF_OP_INIT);
    read_c:     cover property (resp_valid_o && op_reg == DPSF_OP_READ);

endmodule

`default_nettype wire

// file: dpsf_flag_model.sv
`timescale 1ns/10ps
`default_nettype none

// Flag device seen from both sides: the controller is the left port, the bench the right.
module dpsf_flag_model (
    input  wire dpsf_pkg::dpsf_pins_t l_pins_i,  // Left port control pins.
    input  wire logic [15:0]          l_wd_i,    // Left write data.
    output logic [15:0]               l_rd_o,    // Left read data.
    input  wire logic                 r_sel_n_i, // Right flag select.
    input  wire logic                 r_rw_n_i,  // Right write strobe.
    input  wire logic                 r_oe_n_i,  // Right output enable.
    input  wire logic [2:0]           r_idx_i,   // Right flag index.
    input  wire logic                 r_bit_i,   // Right write bit.
    output logic [15:0]               r_rd_o     // Right read data.
);
    import dpsf_pkg::*;
    logic [7:0] req_l, req_r, own_l, own_r;
    logic       lat_l, lat_r;
    wire logic  sel_l = !l_pins_i.flag_space_select_n;
    wire logic  wr_l  = sel_l && !l_pins_i.rw_n;
    wire logic  rd_l  = sel_l && !l_pins_i.output_enable_n && l_pins_i.rw_n;
    wire logic  wr_r  = !r_sel_n_i && !r_rw_n_i;
    wire logic  rd_r  = !r_sel_n_i && !r_oe_n_i && r_rw_n_i;

    // released token passes to pending side.
    task automatic settle(input logic [2:0] i);
        if (own_l[i] && req_l[i]) own_l[i] = 1'b0;
        if (own_r[i] && req_r[i]) own_r[i] = 1'b0;
        if (!own_l[i] && !own_r[i] && !req_l[i]) own_l[i] = 1'b1;
        if (!own_l[i] && !own_r[i] && !req_r[i]) own_r[i] = 1'b1;
    endtask

    // no clean power-up state; left holds every flag with right pending.
    initial begin
        req_l = 8'h00;
        req_r = 8'h00;
        own_l = 8'hFF;
        own_r = 8'h00;
        lat_l = 1'b1;
        lat_r = 1'b1;
    end

    // each port writes bit zero of its own flag.
    always @(posedge wr_l) begin
        #1;
        req_l[l_pins_i.flag_index_lines] = l_wd_i[0];
        settle(l_pins_i.flag_index_lines);
    end
    always @(posedge wr_r) begin
        #1;
        req_r[r_idx_i] = r_bit_i;
        settle(r_idx_i);
    end

    // value latched as select and enable go active, winner sees zero.
    always @(posedge rd_l) begin
        #1;
        lat_l = !own_l[l_pins_i.flag_index_lines];
    end
    always @(posedge rd_r) begin
        #1;
        lat_r = !own_r[r_idx_i];
    end

    // no wait, every bit; a released bus shows the inverse so stale data fails.
    assign l_rd_o = rd_l ? {16{lat_l}} : {16{!lat_l}};
    assign r_rd_o = rd_r ? {16{lat_r}} : {16{!lat_r}};
endmodule

`default_nettype wire

// file: dpsf_host_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module dpsf_host_tb_top;
    import dpsf_pkg::*;
    logic        clock_i, reset_n_i, cmd_valid, cmd_ready, resp_valid, data_oe_n;
    dpsf_cmd_t   cmd;
    dpsf_resp_t  resp;
    dpsf_pins_t  pins;
    logic [15:0] data_drv, mdl_l, r_data;
    logic        r_sel_n, r_rw_n, r_oe_n, r_bit;
    logic [2:0]  r_idx;
    int          err_count, n_checks, ae_low;
    // The controller owns the data pins only while its enable is low.
    wire logic [15:0] data_pin = data_oe_n ? mdl_l : data_drv;

    dpsf_host dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid),
        .cmd_i(cmd), .cmd_ready_o(cmd_ready), .resp_valid_o(resp_valid), .resp_o(resp),
        .pins_o(pins), .data_o(data_drv), .data_oe_n_o(data_oe_n), .data_i(data_pin));
    dpsf_flag_model mdl (.l_pins_i(pins), .l_wd_i(data_drv), .l_rd_o(mdl_l),
        .r_sel_n_i(r_sel_n), .r_rw_n_i(r_rw_n), .r_oe_n_i(r_oe_n), .r_idx_i(r_idx),
        .r_bit_i(r_bit), .r_rd_o(r_data));

    // Free-running bus clock.
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    // flag cycles must never enable the array.
    always @(negedge clock_i) if (reset_n_i && !pins.array_enable_n) ae_low++;

    task print_verdict;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // One command: wait for ready, then count cycles to the pulse and judge it.
    task cmd_run(input dpsf_op_t op, input logic [2:0] idx, input int lat,
                 input logic fl, input logic ow);
        int k;
        @(posedge clock_i);
        cmd_valid <= 1'b1;
        cmd <= '{op, idx};
        k = 0;
        do begin
            @(negedge clock_i);
            k++;
        end while (cmd_ready !== 1'b1 && k < 50);
        // A controller that never returns to idle is a failure, not a hang.
        if (cmd_ready !== 1'b1) begin
            err_count++;
            print_verdict;
        end else begin
            @(posedge clock_i);
            cmd_valid <= 1'b0;
            // Count from one, so the figure names the cycle after the taking edge.
            for (k = 1; k <= 40; k++) begin
                @(negedge clock_i);
                if (resp_valid === 1'b1) break;
            end
            if (k > 40) begin
                err_count++;
                print_verdict;
            end else begin
                check(16'(k), 16'(lat));
                check(16'(resp), 16'({fl, ow, 1'b0}));
                check(16'(pins[6:3]), 16'h000F);
            end
        end
    endtask

    task r_wr(input logic [2:0] i, input logic v);
        @(posedge clock_i);
        r_idx <= i;
        r_bit <= v;
        r_sel_n <= 1'b0;
        r_rw_n <= 1'b0;
        @(posedge clock_i);
        r_sel_n <= 1'b1;
        r_rw_n <= 1'b1;
    endtask

    task r_rd(input logic [2:0] i, input logic v);
        @(posedge clock_i);
        r_idx <= i;
        r_sel_n <= 1'b0;
        r_oe_n <= 1'b0;
        @(negedge clock_i);
        check(r_data, {16{v}});
        @(posedge clock_i);
        r_sel_n <= 1'b1;
        r_oe_n <= 1'b1;
    endtask

    // Initialise from this side; the far side's stale requests take over, then free all.
    task t_init;
        cmd_run(DPSF_OP_INIT, 3'h0, 17, 1'b1, 1'b0);
        r_rd(3'h6, 1'b0);
        for (int i = 0; i < 8; i++) begin
            r_wr(3'(i), 1'b1);
        end
    endtask

    // Acquire one flag; only that index reads low here and high on the far side.
    task t_acquire;
        cmd_run(DPSF_OP_ACQUIRE, 3'h5, 7, 1'b0, 1'b1);
        r_rd(3'h5, 1'b1);
        for (int i = 0; i < 8; i++) begin
            cmd_run(DPSF_OP_READ, 3'(i), 5, i != 5, 1'b0);
        end
    endtask

    // Far side waits, token passes on release, a held read stays stale until reselected.
    task t_pass;
        r_wr(3'h5, 1'b0);
        r_rd(3'h5, 1'b1);
        @(posedge clock_i);
        r_sel_n <= 1'b0;
        r_oe_n <= 1'b0;
        cmd_run(DPSF_OP_RELEASE, 3'h5, 3, 1'b1, 1'b0);
        check(r_data, 16'hFFFF);
        @(posedge clock_i);
        r_sel_n <= 1'b1;
        r_oe_n <= 1'b1;
        r_rd(3'h5, 1'b0);
        cmd_run(DPSF_OP_ACQUIRE, 3'h5, 7, 1'b1, 1'b0);
        cmd_run(DPSF_OP_RELEASE, 3'h5, 3, 1'b1, 1'b0);
        r_wr(3'h5, 1'b1);
        cmd_run(DPSF_OP_ACQUIRE, 3'h5, 7, 1'b0, 1'b1);
    endtask

    initial begin
        reset_n_i = 1'b0;
        cmd_valid = 1'b0;
        cmd = '{DPSF_OP_READ, 3'h0};
        {r_sel_n, r_rw_n, r_oe_n, r_bit} = 4'hF;
        r_idx = 3'h0;
        err_count = 0;
        n_checks = 0;
        ae_low = 0;
        repeat (12) @(posedge clock_i);
        check(16'(pins), 16'(PINS_IDLE));
        reset_n_i <= 1'b1;
        t_init;
        t_acquire;
        t_pass;
        check(16'(ae_low), 16'h0000);
        print_verdict;
    end
endmodule

`default_nettype wire
